// ==== lcd_seg_consts.vh ====
`ifndef LCD_SEG_CONSTS_VH
`define LCD_SEG_CONSTS_VH

// ***************************************
// Time-division modes
// ***************************************
`define MODE_STATIC   2'b00
`define MODE_DIV2     2'b01
`define MODE_DIV3     2'b10
`define MODE_DIV4     2'b11

// ***************************************
// Command byte layout
// ***************************************
`define CMD_OP        7:5
`define OP_LOAD_PTR   3'h0
`define OP_WR_NIB     3'h1
`define OP_BIT        3'h2
`define OP_MODE       3'h3
`define CMD_PTR       4:0
`define CMD_NIB       3:0
`define CMD_BITVAL    4
`define CMD_BITIDX    1:0
`define CMD_MODE      1:0
`define CMD_DEC_EN    2

// ***************************************
// Data byte fields
// ***************************************
`define SEL_14        7
`define CODE_7SEG     3:0
`define CODE_14SEG    6:0

// ***************************************
// Write masks and pointer advances
// ***************************************
`define MSK_1BIT      4'h1
`define MSK_2BIT      4'h3
`define MSK_3BIT      4'h7
`define MSK_4BIT      4'hf
`define ADV_2         3'h2
`define ADV_3         3'h3
`define ADV_4         3'h4

// ***************************************
// APB register map
// ***************************************
`define ADDR_CTRL     12'h000
`define ADDR_PTR      12'h004
`define ADDR_STATUS   12'h008
`define MEM_WIN_SEL   11:7
`define MEM_WIN_HIT   5'h01
`define MEM_WIN_IDX   6:2
`define CTRL_MODE     1:0
`define CTRL_DEC_EN   2
`define STAT_READY    0
`define STAT_REFUSED  1

// ***************************************
// Reset values
// ***************************************
`define RST_MODE      2'b11
`define RST_DEC_EN    1'b0
`define RST_PTR       5'h00
`define RST_NIB       4'h0
`define RST_WORD      32'h0000_0000

`endif

// ==== seg_pattern_rom.v ====
`include "lcd_seg_consts.vh"

// Fixed segment lookup for both decoders; purely combinational
module seg_pattern_rom (
   input  wire [7:0]  code_i,
   output reg  [11:0] pat3_o,
   output reg  [7:0]  pat4_o,
   output reg  [15:0] pat14_o,
   output reg         ok14_o
);

   // ***************************************
   // 7-segment: {N+2,N+1,N} and {N+1,N}
   // ***************************************
   // Sixteen codes: digits 0..9 then six symbols
   always @* begin
      case (code_i[`CODE_7SEG])
         4'h0: begin pat3_o = 12'h353; pat4_o = 8'hd7; end
         4'h1: begin pat3_o = 12'h003; pat4_o = 8'h06; end
         4'h2: begin pat3_o = 12'h271; pat4_o = 8'he3; end
         4'h3: begin pat3_o = 12'h073; pat4_o = 8'ha7; end
         4'h4: begin pat3_o = 12'h123; pat4_o = 8'h36; end
         4'h5: begin pat3_o = 12'h172; pat4_o = 8'hb5; end
         4'h6: begin pat3_o = 12'h372; pat4_o = 8'hf5; end
         4'h7: begin pat3_o = 12'h013; pat4_o = 8'h07; end
         4'h8: begin pat3_o = 12'h373; pat4_o = 8'hf7; end
         4'h9: begin pat3_o = 12'h173; pat4_o = 8'hb7; end
         4'ha: begin pat3_o = 12'h020; pat4_o = 8'h20; end
         4'hb: begin pat3_o = 12'h370; pat4_o = 8'hf1; end
         4'hc: begin pat3_o = 12'h350; pat4_o = 8'hd1; end
         4'hd: begin pat3_o = 12'h060; pat4_o = 8'ha0; end
         4'he: begin pat3_o = 12'h262; pat4_o = 8'he4; end
         default: begin pat3_o = 12'h000; pat4_o = 8'h00; end
      endcase
   end

   // ***************************************
   // 14-segment: {N+3,N+2,N+1,N} by ASCII
   // ***************************************
   // 36 alphanumerics and 13 symbols; other codes flagged unsupported
   always @* begin
      ok14_o = 1'b1;
      case (code_i[`CODE_14SEG])
         7'h20: pat14_o = 16'h0000;
         7'h27: pat14_o = 16'h0002;
         7'h28: pat14_o = 16'h000a;
         7'h29: pat14_o = 16'h5000;
         7'h2a: pat14_o = 16'hf00f;
         7'h2b: pat14_o = 16'ha005;
         7'h2d: pat14_o = 16'h2004;
         7'h2f: pat14_o = 16'h4002;
         7'h30: pat14_o = 16'h47e2;
         7'h31: pat14_o = 16'h0600;
         7'h32: pat14_o = 16'h23c4;
         7'h33: pat14_o = 16'h2784;
         7'h34: pat14_o = 16'h2624;
         7'h35: pat14_o = 16'h25a4;
         7'h36: pat14_o = 16'h25e4;
         7'h37: pat14_o = 16'h0700;
         7'h38: pat14_o = 16'h27e4;
         7'h39: pat14_o = 16'h27a4;
         7'h3c: pat14_o = 16'h4082;
         7'h3d: pat14_o = 16'h2084;
         7'h3e: pat14_o = 16'h1088;
         7'h40: pat14_o = 16'ha7c0;
         7'h41: pat14_o = 16'h2764;
         7'h42: pat14_o = 16'h8785;
         7'h43: pat14_o = 16'h01e0;
         7'h44: pat14_o = 16'h8781;
         7'h45: pat14_o = 16'h21e4;
         7'h46: pat14_o = 16'h2164;
         7'h47: pat14_o = 16'h05e4;
         7'h48: pat14_o = 16'h2664;
         7'h49: pat14_o = 16'h8181;
         7'h4a: pat14_o = 16'h06c0;
         7'h4b: pat14_o = 16'h206a;
         7'h4c: pat14_o = 16'h00e0;
         7'h4d: pat14_o = 16'h1662;
         7'h4e: pat14_o = 16'h1668;
         7'h4f: pat14_o = 16'h07e0;
         7'h50: pat14_o = 16'h2364;
         7'h51: pat14_o = 16'h07e8;
         7'h52: pat14_o = 16'h236c;
         7'h53: pat14_o = 16'h1584;
         7'h54: pat14_o = 16'h8101;
         7'h55: pat14_o = 16'h06e0;
         7'h56: pat14_o = 16'h4062;
         7'h57: pat14_o = 16'h4668;
         7'h58: pat14_o = 16'h500a;
         7'h59: pat14_o = 16'h9002;
         7'h5a: pat14_o = 16'h4182;
         7'h5c: pat14_o = 16'h1008;
         default: begin
            pat14_o = 16'h0000;
            ok14_o  = 1'b0;
         end
      endcase
   end

endmodule // seg_pattern_rom

// ==== lcd_segment_decode_write.v ====
// Decided for this implementation: the APB register port and the register addresses.
`include "lcd_seg_consts.vh"

module lcd_segment_decode_write #(
   parameter AW    = 12,
   parameter DEPTH = 32
) (
   input  wire          clock_i,
   input  wire          srst_i,
   // Latched byte from the serial front end
   input  wire          byte_valid_i,
   input  wire          byte_cmd_i,
   input  wire [7:0]    byte_data_i,
   output reg           byte_ready_o,
   // Display latch read port
   input  wire [4:0]    disp_addr_i,
   output reg  [3:0]    disp_data_o,
   // Current state for the rest of the controller
   output reg  [4:0]    ptr_o,
   output reg  [1:0]    mode_o,
   output reg           dec_en_o,
   // APB slave
   input  wire          psel_i,
   input  wire          penable_i,
   input  wire          pwrite_i,
   input  wire [AW-1:0] paddr_i,
   input  wire [31:0]   pwdata_i,
   output reg  [31:0]   prdata_o,
   output reg           pready_o,
   output reg           pslverr_o
);

   localparam S_IDLE = 1'b0;
   localparam S_EXEC = 1'b1;

   reg        state_q;
   reg [7:0]  byte_q;
   reg        cmd_q;
   reg        refused_q;
   reg [3:0]  mem [0:DEPTH-1];

   wire [11:0] pat3;
   wire [7:0]  pat4;
   wire [15:0] pat14;
   wire        ok14;

   // ***************************************
   // Segment lookup
   // ***************************************
   seg_pattern_rom u_rom (
      .code_i  (byte_q),
      .pat3_o  (pat3),
      .pat4_o  (pat4),
      .pat14_o (pat14),
      .ok14_o  (ok14)
   );

   // ***************************************
   // Data write plan
   // ***************************************
   reg [15:0] wr_val;
   reg [15:0] wr_msk;
   reg [2:0]  wr_cnt;
   reg        wr_ok;
   integer    j;

   // Per-mode spread of raw or decoded data over up to four nibbles
   always @* begin
      wr_val = 16'h0000;
      wr_msk = 16'h0000;
      wr_cnt = `ADV_4;
      wr_ok  = 1'b1;
      if (dec_en_o) begin
         if (byte_q[`SEL_14]) begin
            wr_ok  = (mode_o == `MODE_DIV4) && ok14;
            wr_val = pat14;
            wr_msk = {4{`MSK_4BIT}};
            wr_cnt = `ADV_4;
         end else begin
            case (mode_o)
               `MODE_DIV3: begin
                  wr_val = {4'h0, pat3};
                  wr_msk = {4'h0, {3{`MSK_3BIT}}};
                  wr_cnt = `ADV_3;
               end
               `MODE_DIV4: begin
                  wr_val = {8'h00, pat4};
                  wr_msk = {8'h00, {2{`MSK_4BIT}}};
                  wr_cnt = `ADV_2;
               end
               default: wr_ok = 1'b0;
            endcase
         end
      end else begin
         case (mode_o)
            `MODE_STATIC: begin
               for (j = 0; j < 4; j = j + 1) begin
                  wr_val[j*4 +: 4] = {3'b000, byte_q[j]};
                  wr_msk[j*4 +: 4] = `MSK_1BIT;
               end
            end
            `MODE_DIV2: begin
               for (j = 0; j < 4; j = j + 1) begin
                  wr_val[j*4 +: 4] = {2'b00, byte_q[j*2+1], byte_q[j*2]};
                  wr_msk[j*4 +: 4] = `MSK_2BIT;
               end
            end
            `MODE_DIV3: begin
               // Bit 2 of the third address is forced to zero
               wr_val = {4'h0, 2'b00, byte_q[7:6], 1'b0, byte_q[5:3], 1'b0, byte_q[2:0]};
               wr_msk = {4'h0, {3{`MSK_3BIT}}};
               wr_cnt = `ADV_3;
            end
            default: begin
               wr_val = {8'h00, byte_q};
               wr_msk = {8'h00, {2{`MSK_4BIT}}};
               wr_cnt = `ADV_2;
            end
         endcase
      end
   end

   // ***************************************
   // Slot addresses with wrap
   // ***************************************
   wire [19:0] slot_addr;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_slot
         localparam [4:0] OFS = g;
         assign slot_addr[g*5 +: 5] = ptr_o + OFS;
      end
   endgenerate

   // ***************************************
   // Decode of the latched byte
   // ***************************************
   wire exec      = (state_q == S_EXEC);
   wire do_data   = exec && !cmd_q;
   wire do_cmd    = exec && cmd_q;
   wire op_ptr    = do_cmd && (byte_q[`CMD_OP] == `OP_LOAD_PTR);
   wire op_nib    = do_cmd && (byte_q[`CMD_OP] == `OP_WR_NIB);
   wire op_bit    = do_cmd && (byte_q[`CMD_OP] == `OP_BIT);
   wire op_mode   = do_cmd && (byte_q[`CMD_OP] == `OP_MODE);
   wire data_wr   = do_data && wr_ok;
   wire refuse    = do_data && !wr_ok;

   // ***************************************
   // APB decode
   // ***************************************
   // One wait state: answer lands on the second access cycle
   wire apb_acc   = psel_i && penable_i && !pready_o;
   wire apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
   wire hit_ctrl  = (paddr_i == `ADDR_CTRL);
   wire hit_ptr   = (paddr_i == `ADDR_PTR);
   wire hit_stat  = (paddr_i == `ADDR_STATUS);
   wire hit_mem   = (paddr_i[`MEM_WIN_SEL] == `MEM_WIN_HIT) && (paddr_i[1:0] == 2'b00);
   wire hit_any   = hit_ctrl || hit_ptr || hit_stat || hit_mem;

   // ***************************************
   // Byte handshake
   // ***************************************
   // Exec cycle holds ready low so nothing is taken mid-update
   always @(posedge clock_i) begin
      if (srst_i) begin
         state_q      <= S_IDLE;
         byte_q       <= 8'h00;
         cmd_q        <= 1'b0;
         byte_ready_o <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               byte_ready_o <= 1'b1;
               if (byte_valid_i && byte_ready_o) begin
                  byte_q       <= byte_data_i;
                  cmd_q        <= byte_cmd_i;
                  state_q      <= S_EXEC;
                  byte_ready_o <= 1'b0;
               end
            end
            S_EXEC: begin
               state_q      <= S_IDLE;
               byte_ready_o <= 1'b1;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ***************************************
   // Pointer and mode
   // ***************************************
   // Byte path wins over a same-edge APB write
   always @(posedge clock_i) begin
      if (srst_i) begin
         ptr_o    <= `RST_PTR;
         mode_o   <= `RST_MODE;
         dec_en_o <= `RST_DEC_EN;
      end else begin
         if (apb_wr && hit_ctrl) begin
            mode_o   <= pwdata_i[`CTRL_MODE];
            dec_en_o <= pwdata_i[`CTRL_DEC_EN];
         end
         if (apb_wr && hit_ptr)
            ptr_o <= pwdata_i[4:0];
         if (op_mode) begin
            mode_o   <= byte_q[`CMD_MODE];
            dec_en_o <= byte_q[`CMD_DEC_EN];
         end
         if (op_ptr)
            ptr_o <= byte_q[`CMD_PTR];
         if (op_nib || op_bit)
            ptr_o <= slot_addr[9:5];
         if (data_wr)
            ptr_o <= ptr_o + {2'b00, wr_cnt};
      end
   end

   // ***************************************
   // Display memory
   // ***************************************
   integer k;

   // Read-modify-write keeps bits a mode does not own
   always @(posedge clock_i) begin
      if (srst_i) begin
         for (k = 0; k < DEPTH; k = k + 1)
            mem[k] <= `RST_NIB;
      end else begin
         if (data_wr) begin
            for (k = 0; k < 4; k = k + 1) begin
               if (wr_cnt > k[2:0])
                  mem[slot_addr[k*5 +: 5]] <= (mem[slot_addr[k*5 +: 5]] & ~wr_msk[k*4 +: 4])
                                              | (wr_val[k*4 +: 4] & wr_msk[k*4 +: 4]);
            end
         end
         if (op_nib)
            mem[ptr_o] <= byte_q[`CMD_NIB];
         if (op_bit)
            mem[ptr_o][byte_q[`CMD_BITIDX]] <= byte_q[`CMD_BITVAL];
      end
   end

   // Registered read for the display latch
   always @(posedge clock_i) begin
      if (srst_i)
         disp_data_o <= `RST_NIB;
      else
         disp_data_o <= mem[disp_addr_i];
   end

   // ***************************************
   // Status flag
   // ***************************************
   // A refusal in the clearing cycle still sets the flag
   always @(posedge clock_i) begin
      if (srst_i)
         refused_q <= 1'b0;
      else if (refuse)
         refused_q <= 1'b1;
      else if (apb_wr && hit_stat && pwdata_i[`STAT_REFUSED])
         refused_q <= 1'b0;
   end

   // ***************************************
   // APB answer
   // ***************************************
   always @(posedge clock_i) begin
      if (srst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= `RST_WORD;
      end else begin
         pready_o  <= apb_acc;
         pslverr_o <= apb_acc && !hit_any;
         prdata_o  <= `RST_WORD;
         if (apb_acc && !pwrite_i) begin
            if (hit_ctrl)
               prdata_o <= {29'h0, dec_en_o, mode_o};
            else if (hit_ptr)
               prdata_o <= {27'h0, ptr_o};
            else if (hit_stat)
               prdata_o <= {30'h0, refused_q, byte_ready_o};
            else if (hit_mem)
               prdata_o <= {28'h0, mem[paddr_i[`MEM_WIN_IDX]]};
         end
      end
   end

endmodule // lcd_segment_decode_write

// ==== byte_source.sv ====
// ****************************************
// Serial front end stand-in
// ****************************************
module byte_source (
   input  wire logic       clock_i,
   input  wire logic       ready_i,
   output logic            valid_o,
   output logic            cmd_o,
   output logic [7:0]      data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Nothing offered at start
   initial begin
      valid_o = 1'b0;
      cmd_o = 1'b0;
      data_o = 8'h00;
   end

   // Offer one byte, hold it until taken; gap models a slow front end
   task automatic send(input logic c, input logic [7:0] d, input int gap, output bit ok);
      ok = 1'b0;
      repeat (gap) @(posedge clock_i);
      @(posedge clock_i);
      valid_o <= 1'b1;
      cmd_o <= c;
      data_o <= d;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge clock_i);
         ok = ready_i;
      end
      valid_o <= 1'b0;
      // Released lines carry no stale value
      cmd_o <= ~c;
      data_o <= ~d;
   endtask
endmodule // byte_source

// ==== lcd_segment_decode_write_sva.sv ====
// ****************************************
// Port checker
// ****************************************
module lcd_seg_write_checker #(
   parameter AW = 12
) (
   input wire logic          clock_i,
   input wire logic          srst_i,
   input wire logic          byte_valid_i,
   input wire logic          byte_cmd_i,
   input wire logic [7:0]    byte_data_i,
   input wire logic          byte_ready_o,
   input wire logic [4:0]    ptr_o,
   input wire logic [1:0]    mode_o,
   input wire logic          dec_en_o,
   input wire logic          psel_i,
   input wire logic          penable_i,
   input wire logic          pready_o,
   input wire logic          pslverr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   // Byte handshake; mode is sampled at the take edge, the byte runs one edge later
   logic take;
   logic dtake;
   assign take = byte_valid_i && byte_ready_o;
   assign dtake = take && !byte_cmd_i;

   a_ready_gap: assert property (
      take |=> !byte_ready_o ##1 byte_ready_o) else $error("byte port did not reopen");
   a_load_ptr: assert property (
      take && byte_cmd_i && byte_data_i[7:5] == 3'h0 |-> ##2 ptr_o == $past(byte_data_i[4:0], 2))
      else $error("pointer load wrong");
   a_mode_cmd: assert property (
      take && byte_cmd_i && byte_data_i[7:5] == 3'h3
      |=> ##1 {dec_en_o, mode_o} == $past(byte_data_i[2:0], 2)) else $error("mode command wrong");
   a_nib_step: assert property (
      take && byte_cmd_i && byte_data_i[7:5] == 3'h1 |-> ##2 ptr_o == 5'($past(ptr_o, 2) + 5'd1))
      else $error("nibble write step wrong");
   a_raw_div4: assert property (
      dtake && !dec_en_o && mode_o == 2'b11 |-> ##2 ptr_o == 5'($past(ptr_o, 2) + 5'd2))
      else $error("raw write step wrong");
   a_seg7_div3: assert property (
      dtake && dec_en_o && mode_o == 2'b10 && !byte_data_i[7]
      |-> ##2 ptr_o == 5'($past(ptr_o, 2) + 5'd3)) else $error("decoded write step wrong");
   a_seg14_step: assert property (
      dtake && dec_en_o && mode_o == 2'b11 && byte_data_i[7]
      |-> ##2 (ptr_o == 5'($past(ptr_o, 2) + 5'd4) || ptr_o == $past(ptr_o, 2)))
      else $error("ascii write step wrong");
   a_refuse_hold: assert property (
      dtake && dec_en_o && !mode_o[1] |=> $stable(ptr_o) [*2]) else $error("refused byte moved pointer");
   a_apb_wait: assert property (
      psel_i && penable_i && !pready_o |=> pready_o) else $error("apb answer late");
   a_ready_pulse: assert property (
      $rose(pready_o) |=> !pready_o) else $error("pready longer than one cycle");
   a_err_with_ready: assert property (
      pslverr_o |-> pready_o && psel_i) else $error("error without ready");
endmodule // lcd_seg_write_checker

bind lcd_segment_decode_write lcd_seg_write_checker #(.AW(AW)) chk (
   .clock_i(clock_i), .srst_i(srst_i), .byte_valid_i(byte_valid_i), .byte_cmd_i(byte_cmd_i),
   .byte_data_i(byte_data_i), .byte_ready_o(byte_ready_o), .ptr_o(ptr_o), .mode_o(mode_o),
   .dec_en_o(dec_en_o), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o));

// ==== testbench.sv ====
// ****************************************
// Top-level bench
// ****************************************
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock_i, srst_i, bvalid, bcmd, bready, dec_en, e;
   logic        psel, penable, pwrite, pready, pslverr, x_dec;
   logic [7:0]  bdata;
   logic [4:0]  disp_addr, ptr, x_ptr;
   logic [3:0]  disp_data;
   logic [1:0]  mode, x_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  x_mem [32];
   int          err_count, tests_run;

   // Decoder tables, {N+2,N+1,N} and {N+1,N}
   localparam logic [11:0] seg3 [16] = '{12'h353, 12'h003, 12'h271, 12'h073, 12'h123, 12'h172,
      12'h372, 12'h013, 12'h373, 12'h173, 12'h020, 12'h370, 12'h350, 12'h060, 12'h262, 12'h000};
   localparam logic [7:0] seg4 [16] = '{8'hd7, 8'h06, 8'he3, 8'ha7, 8'h36, 8'hb5, 8'hf5, 8'h07,
      8'hf7, 8'hb7, 8'h20, 8'hf1, 8'hd1, 8'ha0, 8'he4, 8'h00};

   lcd_segment_decode_write uut (.clock_i(clock_i), .srst_i(srst_i), .byte_valid_i(bvalid),
      .byte_cmd_i(bcmd), .byte_data_i(bdata), .byte_ready_o(bready), .disp_addr_i(disp_addr),
      .disp_data_o(disp_data), .ptr_o(ptr), .mode_o(mode), .dec_en_o(dec_en), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   byte_source src (.clock_i(clock_i), .ready_i(bready), .valid_o(bvalid), .cmd_o(bcmd),
      .data_o(bdata));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic er);
      bit ok;
      ok = 1'b0;
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge clock_i);
         ok = pready;
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok) begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic tx(input logic c, input logic [7:0] d, input int gap);
      bit ok;
      src.send(c, d, gap, ok);
      if (!ok) begin
         err_count++;
         give_verdict();
      end
      @(posedge clock_i);
      #1;
   endtask

   task automatic put(input int o, input logic [3:0] v, input logic [3:0] m);
      logic [4:0] a;
      a = 5'(x_ptr + o);
      x_mem[a] = (x_mem[a] & ~m) | (v & m);
   endtask

   task automatic cmd(input logic [7:0] d);
      tx(1'b1, d, 0);
      case (d[7:5])
         3'h0: x_ptr = d[4:0];
         3'h1: begin x_mem[x_ptr] = d[3:0]; x_ptr++; end
         3'h2: begin x_mem[x_ptr][d[1:0]] = d[4]; x_ptr++; end
         3'h3: begin x_mode = d[1:0]; x_dec = d[2]; end
         default: ;
      endcase
      chk(ptr, x_ptr);
      chk({dec_en, mode}, {x_dec, x_mode});
   endtask

   // Expected effect of a data byte; refused cases leave pointer and memory alone
   task automatic dat(input logic [7:0] d, input int gap);
      logic [15:0] t;
      int adv;
      tx(1'b0, d, gap);
      adv = 0;
      t = (d[6:0] == 7'h27) ? 16'h0002 : (d[6:0] == 7'h30) ? 16'h47e2 :
          (d[6:0] == 7'h41) ? 16'h2764 : 16'h0000;
      if (!x_dec) begin
         for (int i = 0; i < 4; i++) begin
            if (x_mode == 2'b00) put(i, {3'h0, d[i]}, 4'h1);
            if (x_mode == 2'b01) put(i, {2'h0, d[2*i+1], d[2*i]}, 4'h3);
         end
         if (x_mode == 2'b10) begin
            put(0, {1'b0, d[2:0]}, 4'h7);
            put(1, {1'b0, d[5:3]}, 4'h7);
            put(2, {2'h0, d[7:6]}, 4'h7);
         end
         if (x_mode == 2'b11) begin
            put(0, d[3:0], 4'hf);
            put(1, d[7:4], 4'hf);
         end
         adv = (x_mode == 2'b10) ? 3 : (x_mode == 2'b11) ? 2 : 4;
      end else if (!d[7] && x_mode == 2'b10) begin
         for (int i = 0; i < 3; i++) put(i, seg3[d[3:0]][4*i+:4], 4'h7);
         adv = 3;
      end else if (!d[7] && x_mode == 2'b11) begin
         put(0, seg4[d[3:0]][3:0], 4'hf);
         put(1, seg4[d[3:0]][7:4], 4'hf);
         adv = 2;
      end else if (d[7] && x_mode == 2'b11) begin
         for (int i = 0; i < 4; i++) put(i, t[4*i+:4], 4'hf);
         adv = 4;
      end
      x_ptr = 5'(x_ptr + adv);
      chk(ptr, x_ptr);
   endtask

   // Whole memory through the display read port
   task automatic chk_mem;
      for (int i = 0; i < 32; i++) begin
         @(posedge clock_i);
         disp_addr <= 5'(i);
         @(posedge clock_i);
         #1;
         chk(disp_data, x_mem[i]);
      end
   endtask

   initial begin
      srst_i = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      disp_addr = 5'h00;
      {err_count, tests_run} = 0;
      {x_ptr, x_mode, x_dec} = {5'h00, 2'b11, 1'b0};
      for (int i = 0; i < 32; i++) x_mem[i] = 4'h0;
      repeat (5) @(posedge clock_i);
      srst_i <= 1'b0;
      apb(1'b0, 12'h000, 32'h0, rd, e);
      chk(rd, 32'h3);
      apb(1'b0, 12'h004, 32'h0, rd, e);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(rd, 32'h1);
      chk_mem();
      $display("reset test done");
      // Nibble and bit commands across the pointer wrap
      cmd(8'h1e);
      cmd(8'h25);
      cmd(8'h52);
      cmd(8'h1e);
      cmd(8'h40);
      cmd(8'hff);
      chk_mem();
      $display("command test done");
      // Raw writes over pre-set nibbles, starting near the top so they wrap
      for (int m = 0; m < 4; m++) begin
         cmd(8'h60 | 8'(m));
         cmd(8'h1e);
         for (int i = 0; i < 4; i++) cmd(8'h2f);
         cmd(8'h1e);
         dat(8'ha5 ^ 8'(m), m);
         chk_mem();
      end
      $display("raw test done");
      // Every 7-segment code in both permitted modes, upper bits set
      for (int m = 3; m >= 2; m--) begin
         cmd(8'h64 | 8'(m));
         cmd(8'h00);
         for (int c = 0; c < 16; c++) dat(8'h70 | 8'(c), c % 3);
         chk_mem();
      end
      $display("seven segment test done");
      // Decoder asked for in modes that forbid it
      cmd(8'h64);
      dat(8'h03, 0);
      cmd(8'h65);
      dat(8'h08, 1);
      cmd(8'h66);
      dat(8'hb0, 0);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(rd, 32'h3);
      apb(1'b1, 12'h008, 32'h2, rd, e);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(rd, 32'h1);
      chk_mem();
      $display("refusal test done");
      // ASCII characters, four nibbles each, then an unsupported code that writes nothing
      cmd(8'h67);
      cmd(8'h1c);
      dat(8'ha0, 0);
      dat(8'ha7, 2);
      dat(8'hb0, 0);
      dat(8'hc1, 1);
      tx(1'b0, 8'ha1, 0);
      chk(ptr, x_ptr);
      chk_mem();
      $display("ascii test done");
      // Register access, unmapped place and read-only memory window
      apb(1'b1, 12'h004, 32'h11, rd, e);
      x_ptr = 5'h11;
      apb(1'b0, 12'h004, 32'h0, rd, e);
      chk(rd, 32'h11);
      chk(ptr, x_ptr);
      apb(1'b1, 12'h000, 32'h6, rd, e);
      {x_dec, x_mode} = 3'h6;
      apb(1'b0, 12'h000, 32'h0, rd, e);
      chk(rd, 32'h6);
      chk({dec_en, mode}, 3'h6);
      dat(8'h05, 0);
      apb(1'b0, 12'h00c, 32'h0, rd, e);
      chk(e, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h08c, 32'hf, rd, e);
      chk(e, 1'b0);
      apb(1'b0, 12'h08c, 32'h0, rd, e);
      chk(rd, {28'h0, x_mem[3]});
      chk_mem();
      $display("register test done");
      give_verdict();
   end
endmodule // testbench
